// ### logic/bic_pkg.sv
package bic_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] BRIDGE_INPUT_CONTROL_OFS = 8'h4F;
  localparam logic [7:0] BRIDGE_INIT_STATUS_OFS = 8'h50;

  // Control register fields
  localparam int CTL_MAP_SEL_BIT = 7;
  localparam int CTL_PIXEL_MODE_BIT = 6;
  localparam int CTL_PORT_SWAP_BIT = 5;
  localparam int CTL_RELOAD_BIT = 1;
  localparam logic CTL_PORT_SWAP_RST = 1'h0;
  localparam logic CTL_RELOAD_RST = 1'h0;

  // Status register fields
  localparam int STS_INIT_DONE_BIT = 4;
  localparam int STS_CFG_DONE_BIT = 2;
  localparam int STS_CKSUM_BIT = 1;
  localparam logic STS_CFG_DONE_RST = 1'h0;
  localparam logic STS_INIT_DONE_RST = 1'h0;
  localparam logic STS_CKSUM_RST = 1'h1;

  // ****************************************
  // Configuration image
  // ****************************************
  localparam int CFG_BYTES = 128;
  localparam int CFG_AW = 7;
  localparam logic [7:0] EE_IMAGE_BASE = 8'h80;
  localparam logic [CFG_AW-1:0] CFG_LAST_IDX = 7'h7F;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] INIT_CNT_LAST = 8'(INIT_CYCLES - 1);
  localparam logic [1:0] STRAP_SETTLE_LAST = 2'h3;

  // Pixel bus width of one input port
  localparam int PIX_W = 28;

  typedef enum logic [2:0] {
    ST_STRAP,
    ST_REQ,
    ST_WAIT_LOW,
    ST_INIT,
    ST_DONE
  } bic_state_t;

endpackage

// ### logic/bic_cfg_mem.sv
`timescale 1ns/1ns
module bic_cfg_mem
  import bic_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [CFG_AW-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // Read side
  input wire logic [CFG_AW-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  logic [7:0] mem_q [CFG_BYTES];

  // Image storage, no reset needed for contents
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read port
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule

// ### logic/bic_bridge_input_control.sv
`timescale 1ns/1ns
// Contract
// - Map select bit 7 picks bit mapping
// - Map select loads from strap pin b
// - Mode bit 6: 0 dual, 1 single
// - Mode bit loads from strap pin a
// - Swap in single mode uses secondary port
// - Swap in dual mode exchanges ports
// - Writing reload bit in done state rereads configuration memory
// - Reload bit self-clears after initialization ends
// - Config-complete bit set after configuration
// - Init-done set only after config-complete
// - Checksum over final 128 EEPROM bytes
// - Status bit 1 shows checksum pass
module bic_bridge_input_control
  import bic_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  // Register access port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Strap pins
  input wire logic STRAP_SELECT_PIN_A_IN,
  input wire logic STRAP_SELECT_PIN_B_IN,
  // External EEPROM byte fetch
  output logic EE_REQ_OUT,
  output logic [7:0] EE_ADDR_OUT,
  input wire logic EE_ACK_IN,
  input wire logic [7:0] EE_DATA_IN,
  // Configuration image readback
  input wire logic [CFG_AW-1:0] CFG_RD_ADDR_IN,
  output logic [7:0] CFG_RD_DATA_OUT,
  // Display input ports
  input wire logic [PIX_W-1:0] PORT_A_DATA_IN,
  input wire logic [PIX_W-1:0] PORT_B_DATA_IN,
  output logic [PIX_W-1:0] PRI_DATA_OUT,
  output logic [PIX_W-1:0] SEC_DATA_OUT,
  // Receiver control
  output logic INPUT_BIT_MAP_SELECT_OUT,
  output logic INPUT_PIXEL_MODE_OUT
);

  // ****************************************
  // Declarations
  // ****************************************
  bic_state_t state_q;
  logic [2:0] strap_a_q;
  logic [2:0] strap_b_q;
  logic [2:0] ack_q;
  logic [7:0] dat_s1_q;
  logic [7:0] dat_s2_q;
  logic [7:0] dat_s3_q;
  logic [1:0] settle_q;
  logic map_sel_q;
  logic pix_mode_q;
  logic swap_q;
  logic reload_q;
  logic cfg_done_q;
  logic init_done_q;
  logic cksum_q;
  logic [CFG_AW-1:0] idx_q;
  logic [7:0] sum_q;
  logic [7:0] init_cnt_q;
  logic ee_req_q;
  logic mem_wr;
  logic ack_high;
  logic ack_low;
  logic data_stable;
  logic ctl_wr;
  logic reload_done;
  logic [7:0] mem_rd_data;
  logic [7:0] ctl_val;
  logic [7:0] sts_val;

  // Address match used by both write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Three stages; only stages two and three are looked at
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      strap_a_q <= 3'h0;
      strap_b_q <= 3'h0;
      ack_q <= 3'h0;
      dat_s1_q <= 8'h00;
      dat_s2_q <= 8'h00;
      dat_s3_q <= 8'h00;
    end else begin
      strap_a_q <= {strap_a_q[1:0], STRAP_SELECT_PIN_A_IN};
      strap_b_q <= {strap_b_q[1:0], STRAP_SELECT_PIN_B_IN};
      ack_q <= {ack_q[1:0], EE_ACK_IN};
      dat_s1_q <= EE_DATA_IN;
      dat_s2_q <= dat_s1_q;
      dat_s3_q <= dat_s2_q;
    end
  end

  // Ack counts once the two later stages agree
  assign ack_high = ack_q[1] & ack_q[2];
  assign ack_low = ~ack_q[1] & ~ack_q[2];
  // Data bus can skew against ack, so wait for it to settle too
  assign data_stable = (dat_s2_q == dat_s3_q);
  assign mem_wr = (state_q == ST_REQ) && ack_high && data_stable;
  assign ctl_wr = REG_WR_IN && hit(REG_ADDR_IN, BRIDGE_INPUT_CONTROL_OFS);
  assign reload_done = (state_q == ST_INIT) && (init_cnt_q == INIT_CNT_LAST);

  // ****************************************
  // Load sequencer
  // ****************************************
  // Straps, image fetch, checksum and init delay in one machine
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_q <= ST_STRAP;
      settle_q <= 2'h0;
      idx_q <= '0;
      sum_q <= 8'h00;
      init_cnt_q <= 8'h00;
      ee_req_q <= 1'b0;
    end else begin
      case (state_q)
        ST_STRAP: begin
          // Let the strap synchronisers fill before trusting them
          settle_q <= settle_q + 2'h1;
          if (settle_q == STRAP_SETTLE_LAST) begin
            state_q <= ST_REQ;
            ee_req_q <= 1'b1;
          end
        end
        ST_REQ: begin
          if (mem_wr) begin
            sum_q <= sum_q + dat_s3_q;
            ee_req_q <= 1'b0;
            state_q <= ST_WAIT_LOW;
          end
        end
        ST_WAIT_LOW: begin
          if (ack_low) begin
            if (idx_q == CFG_LAST_IDX) begin
              init_cnt_q <= 8'h00;
              state_q <= ST_INIT;
            end else begin
              idx_q <= idx_q + 7'h01;
              ee_req_q <= 1'b1;
              state_q <= ST_REQ;
            end
          end
        end
        ST_INIT: begin
          init_cnt_q <= init_cnt_q + 8'h01;
          if (reload_done) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (reload_q) begin
            // Restart the fetch from the first image byte
            idx_q <= '0;
            sum_q <= 8'h00;
            ee_req_q <= 1'b1;
            state_q <= ST_REQ;
          end
        end
        default: begin
          state_q <= ST_STRAP;
          ee_req_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Done flags drop on a new fetch and rise in order
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cfg_done_q <= STS_CFG_DONE_RST;
      init_done_q <= STS_INIT_DONE_RST;
      cksum_q <= STS_CKSUM_RST;
    end else begin
      if (state_q == ST_DONE && reload_q) begin
        cfg_done_q <= 1'b0;
        init_done_q <= 1'b0;
      end else if (state_q == ST_WAIT_LOW && ack_low && idx_q == CFG_LAST_IDX) begin
        cfg_done_q <= 1'b1;
        cksum_q <= (sum_q == 8'h00);
      end else if (reload_done && cfg_done_q) begin
        init_done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Straps give the first map and mode value; software may override later
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      map_sel_q <= 1'b0;
      pix_mode_q <= 1'b0;
      swap_q <= CTL_PORT_SWAP_RST;
    end else begin
      if (state_q == ST_STRAP && settle_q == STRAP_SETTLE_LAST) begin
        map_sel_q <= strap_b_q[2];
        pix_mode_q <= strap_a_q[2];
      end else if (ctl_wr) begin
        map_sel_q <= REG_WDATA_IN[CTL_MAP_SEL_BIT];
        pix_mode_q <= REG_WDATA_IN[CTL_PIXEL_MODE_BIT];
      end
      if (ctl_wr) begin
        swap_q <= REG_WDATA_IN[CTL_PORT_SWAP_BIT];
      end
    end
  end

  // Reload bit: a write of 1 wins over the self-clear
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      reload_q <= CTL_RELOAD_RST;
    end else begin
      if (ctl_wr && REG_WDATA_IN[CTL_RELOAD_BIT]) begin
        reload_q <= 1'b1;
      end else if (reload_done) begin
        reload_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_comb begin
    ctl_val = 8'h00;
    ctl_val[CTL_MAP_SEL_BIT] = map_sel_q;
    ctl_val[CTL_PIXEL_MODE_BIT] = pix_mode_q;
    ctl_val[CTL_PORT_SWAP_BIT] = swap_q;
    ctl_val[CTL_RELOAD_BIT] = reload_q;
    sts_val = 8'h00;
    sts_val[STS_INIT_DONE_BIT] = init_done_q;
    sts_val[STS_CFG_DONE_BIT] = cfg_done_q;
    sts_val[STS_CKSUM_BIT] = cksum_q;
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      if (hit(REG_ADDR_IN, BRIDGE_INPUT_CONTROL_OFS)) begin
        REG_RDATA_OUT <= ctl_val;
      end else if (hit(REG_ADDR_IN, BRIDGE_INIT_STATUS_OFS)) begin
        REG_RDATA_OUT <= sts_val;
      end else begin
        REG_RDATA_OUT <= 8'h00;
      end
    end
  end

  // ****************************************
  // EEPROM request outputs
  // ****************************************
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      EE_REQ_OUT <= 1'b0;
      EE_ADDR_OUT <= 8'h00;
    end else begin
      EE_REQ_OUT <= ee_req_q;
      EE_ADDR_OUT <= EE_IMAGE_BASE | {1'b0, idx_q};
    end
  end

  // ****************************************
  // Configuration image
  // ****************************************
  bic_cfg_mem u_mem (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .wr_en_in(mem_wr),
    .wr_addr_in(idx_q),
    .wr_data_in(dat_s3_q),
    .rd_addr_in(CFG_RD_ADDR_IN),
    .rd_data_out(mem_rd_data)
  );

  // Extra stage so the top output is a local flop
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      CFG_RD_DATA_OUT <= 8'h00;
    end else begin
      CFG_RD_DATA_OUT <= mem_rd_data;
    end
  end

  // ****************************************
  // Input port steering
  // ****************************************
  // Single mode feeds one port only; the other output idles at zero
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PRI_DATA_OUT <= '0;
      SEC_DATA_OUT <= '0;
      INPUT_BIT_MAP_SELECT_OUT <= 1'b0;
      INPUT_PIXEL_MODE_OUT <= 1'b0;
    end else begin
      INPUT_BIT_MAP_SELECT_OUT <= map_sel_q;
      INPUT_PIXEL_MODE_OUT <= pix_mode_q;
      if (pix_mode_q) begin
        PRI_DATA_OUT <= swap_q ? PORT_B_DATA_IN : PORT_A_DATA_IN;
        SEC_DATA_OUT <= '0;
      end else begin
        PRI_DATA_OUT <= swap_q ? PORT_B_DATA_IN : PORT_A_DATA_IN;
        SEC_DATA_OUT <= swap_q ? PORT_A_DATA_IN : PORT_B_DATA_IN;
      end
    end
  end

endmodule

// ### testbench/bic_eeprom_model.sv
`timescale 1ns/1ns
// ****************************************
// Configuration memory on the far side
// ****************************************
module bic_eeprom_model (
  // Clock and handshake
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [7:0] addr_in,
  // Scenario knobs
  input wire logic bad_in,
  input wire logic slow_in,
  // Answer
  output logic ack_out,
  output logic [7:0] data_out
);
  logic [3:0] wait_q = 4'h0;
  logic [7:0] byte_d;
  initial ack_out = 1'b0;
  initial data_out = 8'h00;
  // Image sums to zero; the corrupt knob breaks it
  assign byte_d = (addr_in == 8'hFF) ? 8'hBF : {1'b0, addr_in[6:0]} ^ {7'h00, bad_in && addr_in == 8'h80};
  // Four-phase answer; released data toggles so it is never a stale byte
  always @(posedge clk_in) begin
    if (!req_in) begin
      ack_out <= 1'b0;
      wait_q <= 4'h0;
      data_out <= ~data_out;
    end else if (!ack_out) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q >= (slow_in ? 4'h7 : 4'h0)) begin
        ack_out <= 1'b1;
        data_out <= byte_d;
      end
    end
  end
endmodule

// ### testbench/bic_bridge_input_control_properties.sv
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module bic_bridge_input_control_properties (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic EE_REQ_OUT,
  input wire logic [7:0] EE_ADDR_OUT,
  input wire logic EE_ACK_IN,
  input wire logic [27:0] PORT_A_DATA_IN,
  input wire logic [27:0] PORT_B_DATA_IN,
  input wire logic [27:0] PRI_DATA_OUT,
  input wire logic [27:0] SEC_DATA_OUT,
  input wire logic INPUT_BIT_MAP_SELECT_OUT,
  input wire logic INPUT_PIXEL_MODE_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  map_follow_a: assert property (REG_WR_IN && REG_ADDR_IN == 8'h4F |-> ##2
    INPUT_BIT_MAP_SELECT_OUT == $past(REG_WDATA_IN[7], 2)) else $error("map select wrong");
  mode_follow_a: assert property (REG_WR_IN && REG_ADDR_IN == 8'h4F |-> ##2
    INPUT_PIXEL_MODE_OUT == $past(REG_WDATA_IN[6], 2)) else $error("pixel mode wrong");
  single_sec_a: assert property (INPUT_PIXEL_MODE_OUT && $past(INPUT_PIXEL_MODE_OUT)
    |-> SEC_DATA_OUT == 28'h0) else $error("secondary not idle");
  // Either straight or crossed, never a mix of both
  dual_steer_a: assert property (!INPUT_PIXEL_MODE_OUT && !$past(INPUT_PIXEL_MODE_OUT) && $past(RST_B_IN, 2)
    |-> (PRI_DATA_OUT == $past(PORT_A_DATA_IN) && SEC_DATA_OUT == $past(PORT_B_DATA_IN)) ||
    (PRI_DATA_OUT == $past(PORT_B_DATA_IN) && SEC_DATA_OUT == $past(PORT_A_DATA_IN))) else $error("steer wrong");
  status_rsvd_a: assert property (REG_RD_IN && REG_ADDR_IN == 8'h50 |=>
    (REG_RDATA_OUT & 8'hE9) == 8'h00) else $error("status spare bits set");
  init_order_a: assert property (REG_RDATA_OUT[4] |-> REG_RDATA_OUT[2]) else $error("init before cfg");
  ee_hold_a: assert property ($fell(EE_REQ_OUT) |-> $past(EE_ACK_IN, 2)) else $error("request dropped early");
  ee_gap_a: assert property ($rose(EE_REQ_OUT) |-> !$past(EE_ACK_IN)) else $error("request before ack low");
  ee_range_a: assert property (EE_REQ_OUT |-> EE_ADDR_OUT[7]) else $error("address below image");
  ee_stable_a: assert property (EE_REQ_OUT && $past(EE_REQ_OUT) |-> $stable(EE_ADDR_OUT))
    else $error("address moved");
endmodule
bind bic_bridge_input_control bic_bridge_input_control_properties chk_u (.REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .EE_REQ_OUT(EE_REQ_OUT), .EE_ADDR_OUT(EE_ADDR_OUT), .EE_ACK_IN(EE_ACK_IN),
  .PORT_A_DATA_IN(PORT_A_DATA_IN), .PORT_B_DATA_IN(PORT_B_DATA_IN), .PRI_DATA_OUT(PRI_DATA_OUT),
  .SEC_DATA_OUT(SEC_DATA_OUT), .INPUT_BIT_MAP_SELECT_OUT(INPUT_BIT_MAP_SELECT_OUT),
  .INPUT_PIXEL_MODE_OUT(INPUT_PIXEL_MODE_OUT));

// ### testbench/test_bic_bridge_input_control.sv
`timescale 1ns/1ns
module test_bic_bridge_input_control;
  import bic_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bad = 1'b0;
  logic slow = 1'b0;
  logic sa = 1'b0;
  logic sb = 1'b1;
  logic req, ack, map, mode;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, eaddr, edata, cdata;
  logic [6:0] cidx = 7'h7F;
  logic [27:0] pa = 28'h0;
  logic [27:0] pb = 28'h0;
  logic [27:0] pri, sec;
  int n_errors = 0;
  int n_tests = 0;
  int n_req = 0;
  bic_bridge_input_control dut_u (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr), .REG_WR_IN(wr),
    .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .STRAP_SELECT_PIN_A_IN(sa),
    .STRAP_SELECT_PIN_B_IN(sb), .EE_REQ_OUT(req), .EE_ADDR_OUT(eaddr), .EE_ACK_IN(ack),
    .EE_DATA_IN(edata), .CFG_RD_ADDR_IN(cidx), .CFG_RD_DATA_OUT(cdata), .PORT_A_DATA_IN(pa),
    .PORT_B_DATA_IN(pb), .PRI_DATA_OUT(pri), .SEC_DATA_OUT(sec), .INPUT_BIT_MAP_SELECT_OUT(map),
    .INPUT_PIXEL_MODE_OUT(mode));
  bic_eeprom_model ee_u (.clk_in(clk), .req_in(req), .addr_in(eaddr), .bad_in(bad), .slow_in(slow),
    .ack_out(ack), .data_out(edata));
  always #50 clk = ~clk;
  // Count fetches so a reload can be shown to reread the whole image
  always @(posedge req) n_req++;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Read data lands one cycle after the strobe and then holds
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_init();
    logic [7:0] s;
    for (int i = 0; i < 3000; i++) begin
      rd_reg(8'h50, s);
      if (s[4] === 1'b1) return;
    end
    n_errors++;
    report_and_stop();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Reset with given strap levels; both level pairs are used so a fixed value cannot pass
  task automatic t_reset(input logic a, input logic b);
    logic [7:0] v;
    rst_b = 1'b0;
    sa = a;
    sb = b;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    n_req = 0;
    rd_reg(8'h50, v);
    chk(v, 8'h02);
    repeat (4) @(negedge clk);
    rd_reg(8'h4F, v);
    chk(v, {b, a, 6'h00});
    chk({map, mode}, {b, a});
    wait_init();
    rd_reg(8'h50, v);
    chk(v, 8'h16);
    chk(n_req, 128);
    chk(cdata, 8'hBF);
  endtask
  task automatic t_modes();
    logic [7:0] v;
    pa = 28'h1234567;
    pb = 28'hABCDEF0;
    // Swap differs from both map and mode in some pass, so no bit can stand in for another
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h4F, {i[0], i[1], i[0] ^ i[1], 5'h00});
      repeat (3) @(negedge clk);
      chk({map, mode}, {i[0], i[1]});
      chk(pri, (i[0] ^ i[1]) ? pb : pa);
      chk(sec, i[1] ? 28'h0 : ((i[0] ^ i[1]) ? pa : pb));
      rd_reg(8'h4F, v);
      chk(v, {i[0], i[1], i[0] ^ i[1], 5'h00});
    end
  endtask
  // Bad image is served slowly; good image promptly
  task automatic t_reload(input logic b);
    logic [7:0] v;
    bad = b;
    slow = b;
    n_req = 0;
    wr_reg(8'h4F, 8'h02);
    rd_reg(8'h50, v);
    chk(v & 8'h14, 8'h00);
    rd_reg(8'h4F, v);
    chk(v, 8'h02);
    wait_init();
    rd_reg(8'h4F, v);
    chk(v, 8'h00);
    rd_reg(8'h50, v);
    chk(v, {6'h05, ~b, 1'b0});
    chk(n_req, 128);
  endtask
  task automatic t_refuse();
    logic [7:0] v;
    n_req = 0;
    wr_reg(8'h50, 8'hFF);
    wr_reg(8'h4F, 8'h00);
    repeat (20) @(negedge clk);
    chk(n_req, 0);
    rd_reg(8'h50, v);
    chk(v, 8'h16);
  endtask
  initial begin
    t_reset(1'b0, 1'b1);
    t_modes();
    t_reload(1'b1);
    t_reload(1'b0);
    t_refuse();
    // Second reset in mid-run with the strap levels flipped
    t_reset(1'b1, 1'b0);
    report_and_stop();
  end
endmodule
